// ==== logic/trf_byte_mux.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Record byte selector: byte at one index of the assembled record
// ------------------------------------------------------------------
module trf_byte_mux (
  // Index and sources
  input  wire logic [5:0]         idx,
  input  wire trf_pkg::trf_ident_s ident,
  input  wire trf_pkg::trf_tele_s  tele,
  input  wire logic [7:0]         check_byte,
  // Selected byte
  output logic [7:0]              byte_out
);

  logic [4:0] part_i;
  logic [4:0] tele_i;
  logic [1:0] ser_i;

  // Field sub-indices, cut to width on purpose
  assign part_i = 5'(idx - trf_pkg::OFS_PART);
  assign tele_i = 5'(idx - trf_pkg::OFS_TELE);
  assign ser_i  = 2'(idx - trf_pkg::OFS_SERIAL);

  // Field decode; unmapped bytes (1, 30, 31) read zero
  always_comb begin
    byte_out = trf_pkg::ZERO_BYTE;
    if (idx == trf_pkg::OFS_ECHO) begin
      byte_out = trf_pkg::CMD_READ_ALL;                    // RULE9
    end else if (idx >= trf_pkg::OFS_TELE && idx < trf_pkg::OFS_TELE_END) begin
      // Telemetry words, most significant byte first
      byte_out = tele.words[(trf_pkg::TELE_WORDS*16-1) - tele_i*8 -: 8]; // RULE3 RULE5
    end else if (idx >= trf_pkg::OFS_PART && idx <= trf_pkg::OFS_PART_LAST) begin
      byte_out = ident.part_number[(trf_pkg::PART_CHARS*8-1) - part_i*8 -: 8]; // RULE6
    end else if (idx >= trf_pkg::OFS_SERIAL && idx < trf_pkg::OFS_DATE_WEEK) begin
      byte_out = ident.serial_bcd[31 - ser_i*8 -: 8];     // RULE7
    end else begin
      unique case (idx)
        trf_pkg::OFS_DATE_WEEK:  byte_out = ident.week_bcd;      // RULE8
        trf_pkg::OFS_DATE_YEAR:  byte_out = ident.year_bcd;      // RULE8
        trf_pkg::OFS_HW_REV:     byte_out = ident.hw_rev_major;  // RULE1
        trf_pkg::OFS_HW_REV_LO:  byte_out = ident.hw_rev_minor;  // RULE1
        trf_pkg::OFS_FW_REV:     byte_out = ident.fw_rev_bcd[15:8]; // RULE2
        trf_pkg::OFS_FW_REV_LO:  byte_out = ident.fw_rev_bcd[7:0];  // RULE2
        trf_pkg::OFS_FILLER:     byte_out = trf_pkg::FILLER_BYTE;   // RULE3
        trf_pkg::OFS_CHECK:      byte_out = check_byte;             // RULE4
        default:                 byte_out = trf_pkg::ZERO_BYTE;
      endcase
    end
  end

endmodule : trf_byte_mux

// ==== logic/trf_formatter.sv ====
`timescale 1ns/10ps
// Summary of operation
// [RULE1] Hardware revision: two ASCII bytes 58-59
// [RULE2] Firmware revision: four BCD digits, bytes 60-61
// [RULE3] Byte 62 fixed AA; multibyte fields MSB first
// [RULE4] Byte 63 makes whole record sum zero
// [RULE5] Telemetry words scaled per quantity by host
// [RULE6] Part number ASCII from byte 32, zero padded
// [RULE7] Serial number eight BCD digits, bytes 52-55
// [RULE8] Week byte 56, year byte 57, BCD
// [RULE9] Read-all code 21h, 64 bytes, echoed first
// [RULE10] Checksum recomputed before each record starts
module trf_formatter (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  // Command from the bus slave
  input  wire logic               cmd_valid,
  input  wire logic [7:0]         cmd_code,
  output logic                    cmd_ready,
  // Record sources, sampled at command accept
  input  wire trf_pkg::trf_ident_s ident,
  input  wire trf_pkg::trf_tele_s  tele,
  // Byte stream to the bus slave
  output trf_pkg::trf_byte_s      rec_out,
  input  wire logic               rec_ready,
  // Status
  output logic                    busy,
  output logic                    field_error,
  output logic                    cmd_rejected
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  trf_pkg::trf_state_e state_r;
  trf_pkg::trf_ident_s ident_r;
  trf_pkg::trf_tele_s  tele_r;
  logic [5:0]          idx_r;
  logic [7:0]          sum_r;
  logic [7:0]          check_r;
  logic [7:0]          mux_byte;
  logic [7:0]          out_data_r;
  logic                out_valid_r;
  logic                out_last_r;
  logic [5:0]          out_idx_r;
  logic                field_err_r;
  logic                rejected_r;
  logic                accept;
  logic                out_take;
  logic                fields_bad;

  // Single selector shared by summing and sending passes
  trf_byte_mux trf_byte_mux_i (
    .idx        (idx_r),
    .ident      (ident_r),
    .tele       (tele_r),
    .check_byte (check_r),
    .byte_out   (mux_byte)
  );

  // ----------------------------------------------------------------
  // Command accept
  // ----------------------------------------------------------------
  assign cmd_ready = (state_r == trf_pkg::TRF_IDLE);
  assign accept    = cmd_valid && cmd_ready && (cmd_code == trf_pkg::CMD_READ_ALL); // RULE9
  assign out_take  = out_valid_r && rec_ready;

  // Revision and BCD sanity; bad fields are still sent, flagged only
  always_comb begin
    fields_bad = 1'b0;
    if (ident.hw_rev_major != trf_pkg::ASCII_DASH &&
        (ident.hw_rev_major < trf_pkg::ASCII_UPPER_A ||
         ident.hw_rev_major > trf_pkg::ASCII_UPPER_Z)) begin
      fields_bad = 1'b1;                                   // RULE1
    end
    for (int i = 0; i < 8; i++) begin
      if (ident.serial_bcd[i*4 +: 4] > trf_pkg::BCD_MAX) begin
        fields_bad = 1'b1;                                 // RULE7
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (ident.fw_rev_bcd[i*4 +: 4] > trf_pkg::BCD_MAX) begin
        fields_bad = 1'b1;                                 // RULE2
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (ident.week_bcd[i*4 +: 4] > trf_pkg::BCD_MAX ||
          ident.year_bcd[i*4 +: 4] > trf_pkg::BCD_MAX) begin
        fields_bad = 1'b1;                                 // RULE8
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: snapshot, sum pass over bytes 0..62, then send pass
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= trf_pkg::TRF_IDLE;
      idx_r   <= 6'h00;
    end else begin
      unique case (state_r)
        trf_pkg::TRF_IDLE: begin
          if (accept) begin
            state_r <= trf_pkg::TRF_SUM;                   // RULE10
            idx_r   <= trf_pkg::OFS_ECHO;
          end
        end
        trf_pkg::TRF_SUM: begin
          if (idx_r == trf_pkg::OFS_FILLER) begin
            state_r <= trf_pkg::TRF_SEND;
            idx_r   <= trf_pkg::OFS_ECHO;
          end else begin
            idx_r <= idx_r + 6'h01;
          end
        end
        trf_pkg::TRF_SEND: begin
          // Advance when the output stage is empty or being drained
          if (!out_valid_r || rec_ready) begin
            if (idx_r == trf_pkg::OFS_LAST) begin
              state_r <= trf_pkg::TRF_IDLE;
            end
            idx_r <= idx_r + 6'h01;
          end
        end
        default: state_r <= trf_pkg::TRF_IDLE;
      endcase
    end
  end

  // Snapshot keeps the record self-consistent while it streams
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ident_r <= '0;
      tele_r  <= '0;
    end else if (accept) begin
      ident_r <= ident;
      tele_r  <= tele;
    end
  end

  // Running sum; checksum is its two's complement
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sum_r   <= 8'h00;
      check_r <= 8'h00;
    end else if (accept) begin
      sum_r <= 8'h00;                                      // RULE10
    end else if (state_r == trf_pkg::TRF_SUM) begin
      if (idx_r == trf_pkg::OFS_FILLER) begin
        check_r <= 8'(8'h00 - (sum_r + mux_byte));         // RULE4
      end
      sum_r <= 8'(sum_r + mux_byte);
    end
  end

  // ----------------------------------------------------------------
  // Output register stage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_valid_r <= 1'b0;
      out_last_r  <= 1'b0;
      out_data_r  <= 8'h00;
      out_idx_r   <= 6'h00;
    end else if (state_r == trf_pkg::TRF_SEND && (!out_valid_r || rec_ready)) begin
      out_valid_r <= 1'b1;
      out_last_r  <= (idx_r == trf_pkg::OFS_LAST);
      out_data_r  <= mux_byte;                             // RULE3
      out_idx_r   <= idx_r;
    end else if (out_take) begin
      out_valid_r <= 1'b0;
      out_last_r  <= 1'b0;
    end
  end

  // Sticky status; the next accepted command clears cmd_rejected and reloads field_error
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      field_err_r <= 1'b0;
      rejected_r  <= 1'b0;
    end else begin
      if (accept) begin
        field_err_r <= fields_bad;
      end
      if (cmd_valid && cmd_ready && cmd_code != trf_pkg::CMD_READ_ALL) begin
        rejected_r <= 1'b1;
      end else if (accept) begin
        rejected_r <= 1'b0;
      end
    end
  end

  assign rec_out.valid = out_valid_r;
  assign rec_out.last  = out_last_r;
  assign rec_out.index = out_idx_r;
  assign rec_out.data  = out_data_r;
  assign busy          = (state_r != trf_pkg::TRF_IDLE) || out_valid_r;
  assign field_error   = field_err_r;
  assign cmd_rejected  = rejected_r;

endmodule : trf_formatter

// ==== shared/trf_pkg.sv ====
package trf_pkg;

  // ----------------------------------------------------------------
  // Record layout
  // ----------------------------------------------------------------
  localparam int unsigned REC_LEN        = 64;
  localparam logic [5:0]  OFS_ECHO       = 6'h00;
  localparam logic [5:0]  OFS_PAD1       = 6'h01;
  localparam logic [5:0]  OFS_TELE       = 6'h02;  // 2..29
  localparam logic [5:0]  OFS_TELE_END   = 6'h1e;  // first byte past telemetry
  localparam logic [5:0]  OFS_PART       = 6'h20;  // 32..51
  localparam logic [5:0]  OFS_PART_LAST  = 6'h33;
  localparam logic [5:0]  OFS_SERIAL     = 6'h34;  // 52..55
  localparam logic [5:0]  OFS_DATE_WEEK  = 6'h38;
  localparam logic [5:0]  OFS_DATE_YEAR  = 6'h39;
  localparam logic [5:0]  OFS_HW_REV     = 6'h3a;  // hardware_revision
  localparam logic [5:0]  OFS_HW_REV_LO  = 6'h3b;
  localparam logic [5:0]  OFS_FW_REV     = 6'h3c;  // firmware_revision
  localparam logic [5:0]  OFS_FW_REV_LO  = 6'h3d;
  localparam logic [5:0]  OFS_FILLER     = 6'h3e;  // filler_constant
  localparam logic [5:0]  OFS_CHECK      = 6'h3f;  // zero_sum_check
  localparam logic [5:0]  OFS_LAST       = 6'h3f;
  localparam int unsigned PART_CHARS     = 20;
  localparam int unsigned TELE_WORDS     = 14;     // bytes 2..29

  // ----------------------------------------------------------------
  // Constant byte values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_READ_ALL   = 8'h21;
  localparam logic [7:0]  FILLER_BYTE    = 8'haa;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam logic [7:0]  ASCII_DASH     = 8'h2d;
  localparam logic [7:0]  ASCII_UPPER_A  = 8'h41;
  localparam logic [7:0]  ASCII_UPPER_Z  = 8'h5a;
  localparam logic [3:0]  BCD_MAX        = 4'h9;

  // Telemetry scale numerators over full scale 65535 (host side use)
  localparam real         SCALE_VOLT     = 20.48 / 65535.0;
  localparam real         SCALE_MAIN_I   = 80.0 / 65535.0;
  localparam real         SCALE_AUX_I    = 20.0 / 65535.0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRF_IDLE = 2'b00,
    TRF_SUM  = 2'b01,
    TRF_SEND = 2'b11
  } trf_state_e;

  // Identity fields of the unit, all held by the caller
  typedef struct packed {
    logic [PART_CHARS*8-1:0] part_number;  // char 0 in top byte
    logic [31:0]             serial_bcd;   // 8 digits
    logic [7:0]              week_bcd;
    logic [7:0]              year_bcd;
    logic [7:0]              hw_rev_major; // '-' or 'A'..'Z'
    logic [7:0]              hw_rev_minor;
    logic [15:0]             fw_rev_bcd;   // 4 digits
  } trf_ident_s;

  // Telemetry, 14 words for record bytes 2..29, MSB first
  typedef struct packed {
    logic [TELE_WORDS*16-1:0] words;       // word 0 in top bits
  } trf_tele_s;

  // Byte stream towards the bus slave
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [5:0] index;
    logic [7:0] data;
  } trf_byte_s;

endpackage : trf_pkg

// ==== sim/trf_formatter_assertions.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Record stream checker
// ----------------------------------------------------------------
module trf_formatter_assertions (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                sys_rst,
  // Command side
  input wire logic                cmd_valid,
  input wire logic [7:0]          cmd_code,
  input wire logic                cmd_ready,
  // Sources and stream
  input wire trf_pkg::trf_ident_s ident,
  input wire trf_pkg::trf_tele_s  tele,
  input wire trf_pkg::trf_byte_s  rec_out,
  input wire logic                rec_ready,
  // Status
  input wire logic                busy,
  input wire logic                field_error,
  input wire logic                cmd_rejected
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  trf_pkg::trf_ident_s id_r;
  trf_pkg::trf_tele_s  tl_r;
  logic [7:0]          sum_r;
  wire logic           acc = cmd_valid && cmd_ready && cmd_code == 8'h21;
  wire logic           tk  = rec_out.valid && rec_ready;

  sequence s_accept;
    cmd_valid && cmd_ready && cmd_code == 8'h21;
  endsequence
  sequence s_take;
    rec_out.valid && rec_ready;
  endsequence

  // Fields are latched at accept, so byte checks follow the record in flight
  always_ff @(posedge mclk) begin
    if (acc) begin
      id_r <= ident;
      tl_r <= tele;
    end
  end
  // Running sum of bytes the host took in this record
  always_ff @(posedge mclk) begin
    if (sys_rst) sum_r <= 8'h00;
    else if (tk) sum_r <= (rec_out.index == 6'h00) ? rec_out.data : sum_r + rec_out.data;
  end

  a_echo_first: assert property (rec_out.valid && rec_out.index == 6'h00 |-> rec_out.data == 8'h21)
    else $error("first byte not echo");
  a_filler_byte: assert property (rec_out.valid && rec_out.index == 6'h3e |-> rec_out.data == 8'haa)
    else $error("filler byte wrong");
  a_hold_stall: assert property (rec_out.valid && !rec_ready |=> $stable(rec_out))
    else $error("byte changed while stalled");
  a_index_step: assert property (s_take and !rec_out.last |=> rec_out.valid && rec_out.index == $past(rec_out.index) + 6'd1)
    else $error("index did not advance");
  a_first_latency: assert property (s_accept |-> ##[65:66] rec_out.valid && rec_out.index == 6'h00)
    else $error("record start late");
  a_hw_rev: assert property (rec_out.valid && rec_out.index == 6'h3a |-> rec_out.data == id_r.hw_rev_major)
    else $error("hardware revision byte wrong");
  a_fw_rev: assert property (rec_out.valid && rec_out.index == 6'h3c |-> rec_out.data == id_r.fw_rev_bcd[15:8])
    else $error("firmware revision byte wrong");
  a_serial_top: assert property (rec_out.valid && rec_out.index == 6'h34 |-> rec_out.data == id_r.serial_bcd[31:24])
    else $error("serial byte wrong");
  a_week_byte: assert property (rec_out.valid && rec_out.index == 6'h38 |-> rec_out.data == id_r.week_bcd)
    else $error("week byte wrong");
  a_part_first: assert property (rec_out.valid && rec_out.index == 6'h20 |-> rec_out.data == id_r.part_number[159:152])
    else $error("part number byte wrong");
  a_zero_sum: assert property (s_take and rec_out.last |-> 8'(sum_r + rec_out.data) == 8'h00)
    else $error("record sum not zero");
  a_tele_msb: assert property (rec_out.valid && rec_out.index == 6'h02 |-> rec_out.data == tl_r.words[223:216])
    else $error("telemetry byte order wrong");
  a_accept_busy: assert property (s_accept |=> busy && !cmd_ready)
    else $error("accepted command left ready high");
endmodule : trf_formatter_assertions

// ==== sim/trf_formatter_tb.sv ====
`timescale 1ns/10ps
module trf_formatter_tb;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic                mclk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                cmd_valid = 1'b0;
  logic [7:0]          cmd_code = 8'h00;
  logic                cmd_ready;
  trf_pkg::trf_ident_s id = '0;
  trf_pkg::trf_tele_s  tl = '0;
  trf_pkg::trf_byte_s  rec_out;
  logic                rec_ready;
  logic                busy;
  logic                field_error;
  logic                cmd_rejected;
  logic                stall = 1'b0;
  logic [7:0]          mem [0:63];
  logic                done;
  logic                sum_ok;
  int                  mismatches = 0;
  int                  cmp_count = 0;

  always #5 mclk = ~mclk;

  trf_formatter trf_formatter_i (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .ident(id), .tele(tl), .rec_out(rec_out),
    .rec_ready(rec_ready), .busy(busy), .field_error(field_error), .cmd_rejected(cmd_rejected));
  trf_host_model trf_host_model_i (.mclk(mclk), .rec_out(rec_out), .rec_ready(rec_ready),
    .stall(stall), .mem(mem), .done(done), .sum_ok(sum_ok));

  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Offer one command for a cycle; for read-all wait out the record
  task automatic run_rec(input logic [7:0] code);
    int n;
    n = 0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge mclk);
    if (code == 8'h21) begin
      chk("cmd_ready", 8'h00, {7'h0, cmd_ready});
      chk("busy", 8'h01, {7'h0, busy});
      // Foreign code while busy must be ignored, not flagged
      cmd_code = 8'h22;
      @(negedge mclk);
    end
    cmd_valid = 1'b0;
    if (code == 8'h21) begin
      repeat (67) @(negedge mclk);
      while (done !== 1'b1 && n < 300) begin
        @(negedge mclk);
        n++;
      end
      chk("done", 8'h01, {7'h0, done});
    end
  endtask : run_rec

  // Expected record built from the field layout, checksum last
  task automatic check_rec();
    logic [7:0] e [0:63];
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 63; i++) begin
      e[i] = (i >= 2 && i < 30) ? tl.words[223 - 8 * (i - 2) -: 8] : 8'h00;
      if (i == 0) e[i] = 8'h21;
      if (i >= 32) e[i] = (i == 62) ? 8'haa : id[239 - 8 * (i - 32) -: 8];
      s = s + e[i];
    end
    e[63] = 8'h00 - s;
    for (int i = 0; i < 64; i++) begin
      chk($sformatf("byte %0d", i), e[i], mem[i]);
    end
    chk("sum_ok", 8'h01, {7'h0, sum_ok});
  endtask : check_rec

  // Main sequence: refusal, plain record, stalled record, bad digits
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    chk("busy", 8'h00, {7'h0, busy});
    run_rec(8'h22);
    chk("cmd_rejected", 8'h01, {7'h0, cmd_rejected});
    id = {"PSU-A7", 112'h0, 32'h0000_0025, 8'h35, 8'h18, 8'h2d, 8'h41, 16'h3907};
    tl.words = {7{32'hffff_0001}};
    run_rec(8'h21);
    check_rec();
    // Full-scale voltage word read back through the host scale
    cmp_count++;
    if (!({mem[6], mem[7]} * trf_pkg::SCALE_VOLT > 20.47)) begin
      mismatches++;
      $display("[ERR] volts expected 20.48 seen %f", {mem[6], mem[7]} * trf_pkg::SCALE_VOLT);
    end
    chk("cmd_rejected", 8'h00, {7'h0, cmd_rejected});
    stall = 1'b1;
    id = {"X9", 144'h0, 32'h9999_9999, 8'h52, 8'h99, 8'h5a, 8'h42, 16'h9999};
    tl.words = {14{16'h5a3c}};
    run_rec(8'h21);
    check_rec();
    chk("field_error", 8'h00, {7'h0, field_error});
    stall = 1'b0;
    id.serial_bcd = 32'h0000_00a1;
    run_rec(8'h21);
    check_rec();
    chk("field_error", 8'h01, {7'h0, field_error});
    end_sim();
  end

  // Three short records and one refused command need under 700 cycles; generous margin
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
endmodule : trf_formatter_tb

bind trf_formatter trf_formatter_assertions trf_formatter_assertions_i (.mclk(mclk),
  .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
  .ident(ident), .tele(tele), .rec_out(rec_out), .rec_ready(rec_ready), .busy(busy),
  .field_error(field_error), .cmd_rejected(cmd_rejected));

// ==== sim/trf_host_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Management host reading the record
// ----------------------------------------------------------------
module trf_host_model (
  // Clock and stream
  input  wire logic               mclk,
  input  wire trf_pkg::trf_byte_s rec_out,
  output logic                    rec_ready,
  // Control and results
  input  wire logic               stall,
  output logic [7:0]              mem [0:63],
  output logic                    done,
  output logic                    sum_ok
);
  logic [7:0] sum_r;

  initial rec_ready = 1'b1;
  // Slow host accepts every other cycle to exercise holding
  always @(negedge mclk) begin
    rec_ready <= stall ? ~rec_ready : 1'b1;
  end
  // Store taken bytes; sum_ok flags a record whose sum is zero
  always @(posedge mclk) begin
    if (rec_out.valid && rec_ready) begin
      mem[rec_out.index] <= rec_out.data;
      sum_r <= ((rec_out.index == 6'h00) ? 8'h00 : sum_r) + rec_out.data;
      done <= rec_out.last;
      sum_ok <= rec_out.last && 8'(sum_r + rec_out.data) == 8'h00;
    end
  end
endmodule : trf_host_model
